// file: hw/adc_output_cal_control.sv
// Purpose: sample output, clock division and self-calibration control
// Assumes: hclk is the input clock; inputs are synchronous to it
// Notes:   raw samples arrive as offset-binary codes with an over flag
//
// How it works
// - a sample's word reaches the outputs 28 sample ticks after it starts
// - 24 ticks of conversion stages, then correction stages fill the rest
// - after reset, calibrate and hold the reset pin low until done
// - reference select low picks internal, high or open picks external
// - halve select low divides the input clock by two
// - halve select high runs undivided; divider uses rising edges only
// - coding select low gives two's complement output
// - eight-bit word, bit 0 least significant, bit 7 most significant
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module adc_output_cal_control
  import adc_ctrl_pkg::*;
#(
  parameter int unsigned CAL_TICKS = CAL_TICKS_DEFAULT
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // raw samples from the converter core
  input  wire logic        raw_valid,
  output logic             raw_ready,
  input  wire logic [7:0]  raw_code,
  input  wire logic        raw_over,
  // open-drain reset pin
  input  wire logic        rst_pin_in,
  output logic             rst_pin_out,
  output logic             rst_pin_oe,
  // reference control
  output logic             ref_internal_en,
  // sample outputs
  output logic [7:0]       sample_data,
  output logic             over_range,
  output logic             sample_clock_out,
  output logic             sample_valid
);
  // ==========================================================================
  // register bus
  logic [CFG_WIDTH-1:0]    cfg;
  logic                    wr_pend;
  logic [7:0]              wr_addr;
  logic [7:0]              cal_runs;
  logic [FIFO_LEVEL_BITS-1:0] fifo_level;
  cal_state_e              state;

  // address phase decode
  wire        take     = hsel && hready && htrans[1];
  wire [7:0]  rd_addr  = haddr[7:0];
  wire        cfg_we   = wr_pend && (wr_addr == OFF_CONFIG);
  wire        ctrl_we  = wr_pend && (wr_addr == OFF_CONTROL);
  wire        recal_req = ctrl_we && hwdata[CTRL_RECAL_BIT];
  wire [CFG_WIDTH-1:0] next_cfg = cfg_we ? hwdata[CFG_WIDTH-1:0] : cfg;

  // status word and read mux, forwarding a write still in flight
  wire [31:0] status_word = {24'h0, fifo_level, 1'b0, (fifo_level == '0),
                             (fifo_level == FIFO_LEVEL_BITS'(FIFO_DEPTH)),
                             (state == ST_CAL)};
  wire [31:0] rd_mux =
      (rd_addr == OFF_CONFIG)   ? {29'h0, next_cfg} :
      (rd_addr == OFF_STATUS)   ? status_word :
      (rd_addr == OFF_CALCOUNT) ? {24'h0, cal_runs} :
                                  32'h0000_0000;

  assign hreadyout = 1'b1; // zero wait states
  assign hresp     = 1'b0; // always okay

  // capture address phase, load read data for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_pend <= take && hwrite;
      if (take) wr_addr <= rd_addr;
      if (take && !hwrite) hrdata <= rd_mux;
    end
  end

  // configuration register, open-pin levels at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cfg <= CFG_RESET;
    else cfg <= next_cfg;
  end

  wire cfg_halve_n = cfg[CFG_HALVE_N_BIT];
  wire cfg_twos_n  = cfg[CFG_TWOS_N_BIT];
  wire cfg_ref_sel = cfg[CFG_REF_SEL_BIT];

  // internal buffer only when external is not selected
  assign ref_internal_en = !cfg_ref_sel;

  // ==========================================================================
  // sample clock divider
  logic div_phase;
  wire  tick = cfg_halve_n || div_phase;

  // toggles on rising edges only, so every other edge is a tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_phase <= 1'b0;
    else div_phase <= cfg_halve_n ? 1'b0 : !div_phase;
  end

  // ==========================================================================
  // calibration control
  logic                    halve_prev;
  logic [CAL_CNT_BITS-1:0] cal_count;
  logic [3:0]              low_count;

  wire ratio_change = cfg_halve_n != halve_prev;
  wire ext_recal    = (state == ST_RUN) && tick && !rst_pin_in &&
                      (low_count == RECAL_MIN_PERIODS - 4'h1);
  wire cal_done     = (state == ST_CAL) && tick && !ratio_change &&
                      (cal_count == CAL_CNT_BITS'(CAL_TICKS - 1));
  wire go_cal       = ratio_change || recal_req || ext_recal;

  // open drain: only ever pulls low, and only while calibrating
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe  = state == ST_CAL;

  // state, calibration length and run count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= ST_CAL;
      cal_count  <= '0;
      cal_runs   <= 8'h00;
      halve_prev <= CFG_RESET[CFG_HALVE_N_BIT];
    end else begin
      halve_prev <= cfg_halve_n;
      if (go_cal) begin
        state     <= ST_CAL;
        cal_count <= '0;
      end else if (cal_done) begin
        state    <= ST_RUN;
        cal_runs <= cal_runs + 8'h01;
      end else if (state == ST_CAL && tick) begin
        cal_count <= cal_count + 1'b1;
      end
    end
  end

  // sample periods with the pin held low by the partner
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) low_count <= 4'h0;
    else if (state != ST_RUN || rst_pin_in) low_count <= 4'h0;
    else if (tick && low_count != 4'hF) low_count <= low_count + 4'h1;
  end

  // ==========================================================================
  // data path: fifo, conversion stages, correction stages
  logic                 fifo_valid;
  logic [WORD_BITS-1:0] fifo_word;
  wire                  running = state == ST_RUN;
  wire                  pop     = fifo_valid && running && tick;

  stage_link_if #(.W(WORD_BITS)) conv_lnk ();
  stage_link_if #(.W(WORD_BITS)) corr_lnk ();

  sample_fifo #(
    .W     (WORD_BITS),
    .DEPTH (FIFO_DEPTH),
    .LW    (FIFO_LEVEL_BITS)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (raw_valid),
    .in_ready  (raw_ready),
    .in_data   ({raw_over, raw_code}),
    .out_valid (fifo_valid),
    .out_ready (running && tick),
    .out_data  (fifo_word),
    .level     (fifo_level)
  );

  // conversion stages, fed one slot per tick, a bubble if empty
  assign conv_lnk.step     = tick;
  assign conv_lnk.flush    = !running;
  assign conv_lnk.in_valid = pop;
  assign conv_lnk.in_word  = fifo_word;

  stage_chain #(
    .W     (WORD_BITS),
    .DEPTH (CONV_STAGES)
  ) u_conv (
    .hclk    (hclk),
    .hresetn (hresetn),
    .lnk     (conv_lnk)
  );

  // correction stages finish the fixed latency
  assign corr_lnk.step     = tick;
  assign corr_lnk.flush    = !running;
  assign corr_lnk.in_valid = conv_lnk.out_valid;
  assign corr_lnk.in_word  = conv_lnk.out_word;

  stage_chain #(
    .W     (WORD_BITS),
    .DEPTH (CORR_STAGES)
  ) u_corr (
    .hclk    (hclk),
    .hresetn (hresetn),
    .lnk     (corr_lnk)
  );

  // ==========================================================================
  // output coding and output clock
  wire       out_load  = running && !go_cal && tick && corr_lnk.out_valid;
  wire [7:0] corr_code = corr_lnk.out_word[SAMPLE_BITS-1:0];
  wire [7:0] coded     = cfg_twos_n ? corr_code
                                    : {!corr_code[7], corr_code[6:0]};

  // word, flag and clock edge leave together
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_data      <= 8'h00;
      over_range       <= 1'b0;
      sample_clock_out <= 1'b0;
      sample_valid     <= 1'b0;
    end else begin
      sample_valid <= out_load;
      if (out_load) begin
        sample_data      <= coded;
        over_range       <= corr_lnk.out_word[SAMPLE_BITS];
        sample_clock_out <= !sample_clock_out;
      end
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_start_undiv;
    pop && cfg_halve_n;
  endsequence

  sequence s_word_out;
    sample_valid && (sample_clock_out != $past(sample_clock_out));
  endsequence

  a_total_latency: assert property (
    disable iff (!hresetn || !running || ratio_change || !cfg_halve_n)
    s_start_undiv |-> ##29 s_word_out)
    else $error("sample word late or missing");

  a_conv_depth: assert property (
    disable iff (!hresetn || !running || ratio_change || !cfg_halve_n)
    s_start_undiv |-> ##24 conv_lnk.out_valid)
    else $error("conversion stage depth wrong");

  a_cal_holds_pin: assert property (
    (state == ST_CAL) |-> (rst_pin_oe && !rst_pin_out && !sample_valid) ##1 !sample_valid)
    else $error("reset pin not held during calibration");

  a_cal_release: assert property (
    cal_done && !go_cal |=> (state == ST_RUN) && !rst_pin_oe)
    else $error("calibration end not released");

  a_ref_select: assert property (
    $changed(cfg_ref_sel) |-> (ref_internal_en == !cfg_ref_sel))
    else $error("reference select wrong");

  a_halve_alternate: assert property (
    (!cfg_halve_n && !ratio_change)[*2] |-> (tick != $past(tick)))
    else $error("divided tick not alternating");

  a_undivided_tick: assert property (
    cfg_halve_n |-> tick)
    else $error("undivided tick missing");

  a_twos_coding: assert property (
    sample_valid && !$past(cfg_twos_n) |->
      sample_data == {!$past(corr_code[7]), $past(corr_code[6:0])})
    else $error("two's complement coding wrong");

  a_offset_coding: assert property (
    sample_valid && $past(cfg_twos_n) |-> sample_data == $past(corr_code))
    else $error("offset binary coding wrong");

  a_over_aligned: assert property (
    sample_valid |-> over_range == $past(corr_lnk.out_word[SAMPLE_BITS]))
    else $error("over-range flag misaligned");

  a_clock_with_word: assert property (
    $changed(sample_clock_out) |-> sample_valid)
    else $error("output clock moved without a word");

  a_no_data_while_cal: assert property (
    $rose(state == ST_CAL) |=> !sample_valid[*3])
    else $error("word left during calibration");

  // calibration freshly entered: pin pulled, length counter cleared
  sequence s_recal_begin;
    (state == ST_CAL) && rst_pin_oe && (cal_count == '0);
  endsequence

  // ten low ticks on the pin while running restart calibration
  a_pin_recal: assert property (
    ext_recal |=> s_recal_begin)
    else $error("pin pull did not restart calibration");

  // a recalibration write restarts calibration
  a_write_recal: assert property (
    recal_req |=> s_recal_begin)
    else $error("recalibration write ignored");

  // a change of clock ratio restarts calibration
  a_ratio_recal: assert property (
    ratio_change |=> s_recal_begin)
    else $error("clock ratio change did not recalibrate");

  // the pin is only ever pulled low
  a_pin_never_high: assert property (
    !rst_pin_out)
    else $error("reset pin driven high");

  // calibration empties both stage chains
  a_cal_flushes: assert property (
    (state == ST_CAL) |=> !conv_lnk.out_valid && !corr_lnk.out_valid)
    else $error("stage chain not flushed by calibration");
endmodule
`default_nettype wire

// file: hw/adc_ctrl_pkg.sv
// Purpose: shared constants for the converter output and calibration control
// Assumes: one 10 MHz clock, AHB-Lite register access with 32-bit data
// Notes:   offsets are byte addresses, one register per aligned word
package adc_ctrl_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0] OFF_CONFIG   = 8'h00;
  localparam logic [7:0] OFF_CONTROL  = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_CALCOUNT = 8'h0C;
  // config fields, reset to the open-pin levels (all high)
  localparam int         CFG_HALVE_N_BIT = 0;
  localparam int         CFG_TWOS_N_BIT  = 1;
  localparam int         CFG_REF_SEL_BIT = 2;
  localparam int         CFG_WIDTH       = 3;
  localparam logic [2:0] CFG_RESET       = 3'h7;
  // control fields
  localparam int         CTRL_RECAL_BIT = 0;
  // status fields
  localparam int         ST_CAL_BIT   = 0;
  localparam int         ST_FULL_BIT  = 1;
  localparam int         ST_EMPTY_BIT = 2;
  localparam int         ST_LEVEL_LSB = 4;
  // ==========================================================================
  // data path and timing
  localparam int          SAMPLE_BITS       = 8;
  localparam int          WORD_BITS         = SAMPLE_BITS + 1;
  localparam int          LATENCY_TICKS     = 28;
  localparam int          CONV_STAGES       = 24;
  localparam int          CORR_STAGES       = LATENCY_TICKS - CONV_STAGES;
  localparam int          FIFO_DEPTH        = 8;
  localparam int          FIFO_LEVEL_BITS   = 4;
  localparam logic [3:0]  RECAL_MIN_PERIODS = 4'hA;
  localparam int unsigned CAL_TICKS_DEFAULT = 1024;
  localparam int          CAL_CNT_BITS      = 16;
  // controller state, one-hot
  typedef enum logic [1:0] {
    ST_CAL = 2'b01,
    ST_RUN = 2'b10
  } cal_state_e;
endpackage

// file: hw/stage_link_if.sv
// Purpose: carrier between the control module and a delay stage chain
// Assumes: single clock domain
// Notes:   word is {over-range, code}
`timescale 1ns/1ps
`default_nettype none
interface stage_link_if #(parameter int W = 9);
  logic         step;
  logic         flush;
  logic         in_valid;
  logic [W-1:0] in_word;
  logic         out_valid;
  logic [W-1:0] out_word;
  modport feed  (output step, flush, in_valid, in_word, input out_valid, out_word);
  modport chain (input step, flush, in_valid, in_word, output out_valid, out_word);
endinterface
`default_nettype wire

// file: hw/sample_fifo.sv
// Purpose: word buffer in front of the conversion pipeline
// Assumes: DEPTH is a power of two
// Notes:   full and empty come from the occupancy count
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8,
  parameter int LW    = 4
) (
  // clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // fill side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  // drain side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  // occupancy
  output logic [LW-1:0]      level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  // handshakes
  assign in_ready  = level != LW'(DEPTH);
  assign out_valid = level != '0;
  assign out_data  = mem[rd_ptr];

  // pointers and count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      level <= level + LW'(push) - LW'(pop);
    end
  end

  // storage
  always_ff @(posedge hclk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule
`default_nettype wire

// file: hw/stage_chain.sv
// Purpose: fixed-depth delay line that advances once per sample tick
// Assumes: flush empties every slot at once
// Notes:   a slot holds a valid flag and a word
`timescale 1ns/1ps
`default_nettype none
module stage_chain #(
  parameter int W     = 9,
  parameter int DEPTH = 24
) (
  // clock and reset
  input  wire logic   hclk,
  input  wire logic   hresetn,
  // link to the controller
  stage_link_if.chain lnk
);
  logic [DEPTH-1:0] vld;
  logic [W-1:0]     word [DEPTH];

  assign lnk.out_valid = vld[DEPTH-1];
  assign lnk.out_word  = word[DEPTH-1];

  // one slot per stage
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        vld[i]  <= 1'b0;
        word[i] <= '0;
      end else if (lnk.flush) begin
        vld[i] <= 1'b0;
      end else if (lnk.step) begin
        vld[i]  <= (i == 0) ? lnk.in_valid : vld[(i == 0) ? 0 : i - 1];
        word[i] <= (i == 0) ? lnk.in_word : word[(i == 0) ? 0 : i - 1];
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/capture_partner.sv
// Purpose: capture-side partner that collects words and pulls the reset pin
// Assumes: one clock; the reset pin is open drain
// Notes:   the bench resolves the pin level from every pull
`timescale 1ns/1ps
`default_nettype none
module capture_partner (
  // clock
  input  wire logic       hclk,
  // sample side
  input  wire logic [7:0] sample_data,
  input  wire logic       over_range,
  input  wire logic       sample_clock_out,
  input  wire logic       sample_valid,
  // open-drain pull, never driven high
  output logic            pull_low
);
  // ==========================================================================
  // captured words, {clock, over, data}
  logic [9:0] got[$];
  initial pull_low = 1'b0;
  // capture on each word pulse
  always @(posedge hclk) begin
    if (sample_valid) begin
      got.push_back({sample_clock_out, over_range, sample_data});
    end
  end
  // pull the pin low for n clock cycles, release by letting go
  task automatic pull(input int n);
    pull_low <= 1'b1;
    repeat (n) @(posedge hclk);
    pull_low <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: testbench/adc_output_cal_control_bench.sv
// Purpose: self-checking bench for sample output and calibration control
// Assumes: 10 MHz hclk, short calibration count in simulation
// Notes:   the partner captures words and owns the reset pin pull
`timescale 1ns/1ps
`default_nettype none
module adc_output_cal_control_bench
  import adc_ctrl_pkg::*;
;
  localparam int CAL_T = 16;
  // ==========================================================================
  // signals
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        raw_valid;
  logic        raw_ready;
  logic [7:0]  raw_code;
  logic        raw_over;
  logic        rst_pin_out;
  logic        rst_pin_oe;
  logic        pull_low;
  wire logic   rst_pin_in;
  logic        ref_internal_en;
  logic [7:0]  sample_data;
  logic        over_range;
  logic        sample_clock_out;
  logic        sample_valid;
  int          miscompares;
  int          total_checks;
  int          cyc;
  int          rel;
  logic [31:0] rd;
  logic [8:0]  wq[$];
  // pin level: any pull wins, weak internal high otherwise
  assign rst_pin_in = ~((rst_pin_oe & ~rst_pin_out) | pull_low);
  // ==========================================================================
  // design and partner
  adc_output_cal_control #(.CAL_TICKS(CAL_T)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .raw_valid(raw_valid), .raw_ready(raw_ready),
    .raw_code(raw_code), .raw_over(raw_over), .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .ref_internal_en(ref_internal_en),
    .sample_data(sample_data), .over_range(over_range),
    .sample_clock_out(sample_clock_out), .sample_valid(sample_valid));
  capture_partner P (
    .hclk(hclk), .sample_data(sample_data), .over_range(over_range),
    .sample_clock_out(sample_clock_out), .sample_valid(sample_valid), .pull_low(pull_low));
  // clock and cycle count
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;
  // ==========================================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic limit_hit(input string what, input int n, input int lmt);
    if (n >= lmt) begin
      miscompares++;
      $display("BAD %s exp answer got timeout", what);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // one single transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    limit_hit("hready", n, 50);
    rd = hrdata;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(what, e, rd);
  endtask
  // offer words back to back, valid held across them
  task automatic send(input logic [8:0] w[$]);
    int n;
    n = 0;
    raw_valid <= 1'b1;
    foreach (w[i]) begin
      {raw_over, raw_code} <= w[i];
      @(posedge hclk);
      while (raw_ready !== 1'b1 && n < 100) begin
        @(posedge hclk);
        n++;
      end
    end
    limit_hit("raw ready", n, 100);
    raw_valid <= 1'b0;
  endtask
  task automatic wait_oe(input logic v, input int lim);
    int n;
    n = 0;
    while (rst_pin_oe !== v && n < lim) begin
      @(posedge hclk);
      n++;
    end
    limit_hit("pin enable", n, lim);
  endtask
  task automatic wait_words(input int k);
    int n;
    n = 0;
    while (P.got.size() < k && n < 300) begin
      @(posedge hclk);
      n++;
    end
    limit_hit("word count", n, 300);
  endtask
  task automatic cmp_words(input logic [8:0] w[$], input logic [8:0] flip);
    foreach (w[i]) begin
      chk("word", 32'(w[i] ^ flip), 32'(P.got[i][8:0]));
      if (i > 0) chk("clock toggle", 32'(!P.got[i-1][9]), 32'(P.got[i][9]));
    end
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    chk("oe in reset", 1, rst_pin_oe);
    chk("pin never high", 0, rst_pin_out);
    chk("valid in reset", 0, sample_valid);
  endtask
  task automatic t_fill_cal();
    rdc("config reset", OFF_CONFIG, 32'(CFG_RESET));
    send(wq);
    @(posedge hclk);
    chk("ready when full", 0, raw_ready);
    rdc("status full", OFF_STATUS, 32'h00000083);
    chk("no word in cal", 0, P.got.size());
    wait_oe(1'b0, 100);
    chk("cal length", 1, 32'(cyc - rel >= CAL_T && cyc - rel <= CAL_T + 3));
    wait_words(8);
    cmp_words(wq, 9'h000);
    rdc("cal count", OFF_CALCOUNT, 32'h00000001);
  endtask
  task automatic t_latency(input int lo, input int hi);
    int n;
    n = 0;
    send('{9'h13C});
    while (sample_valid !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    chk("latency", 1, 32'(n >= lo && n <= hi));
    chk("data", 32'h0000003C, sample_data);
    chk("over", 1, over_range);
  endtask
  task automatic t_ref();
    wr_cfg(32'h00000003);
    chk("ref internal", 1, ref_internal_en);
    rdc("config back", OFF_CONFIG, 32'h00000003);
    wr_cfg(32'h00000007);
    chk("ref external", 0, ref_internal_en);
    chk("okay", 0, hresp);
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    rdc("unmapped", 8'h40, 32'h00000000);
    rdc("control reads", OFF_CONTROL, 32'h00000000);
  endtask
  task automatic wr_cfg(input logic [31:0] d);
    bus(1'b1, OFF_CONFIG, d);
    @(posedge hclk);
  endtask
  task automatic t_coding();
    P.got.delete();
    wr_cfg(32'h00000005);
    send(wq);
    wait_words(8);
    cmp_words(wq, 9'h080);
    wr_cfg(32'h00000007);
  endtask
  task automatic t_halve();
    wr_cfg(32'h00000006);
    wait_oe(1'b1, 4);
    chk("recal on halve", 1, rst_pin_oe);
    wait_oe(1'b0, 2 * CAL_T + 10);
    t_latency(2 * LATENCY_TICKS + 2, 2 * LATENCY_TICKS + 3);
    wr_cfg(32'h00000007);
    wait_oe(1'b1, 4);
    wait_oe(1'b0, CAL_T + 10);
    t_latency(LATENCY_TICKS + 2, LATENCY_TICKS + 2);
  endtask
  task automatic t_pin();
    logic [31:0] c;
    bus(1'b0, OFF_CALCOUNT, 32'h00000000);
    c = rd;
    P.pull(9);
    repeat (4) @(posedge hclk);
    chk("short pull ignored", 0, rst_pin_oe);
    P.pull(10);
    wait_oe(1'b1, 4);
    chk("pull starts recal", 1, rst_pin_oe);
    wait_oe(1'b0, CAL_T + 10);
    rdc("count after pull", OFF_CALCOUNT, c + 1);
    bus(1'b1, OFF_CONTROL, 32'h00000001);
    wait_oe(1'b1, 4);
    chk("write recal", 1, rst_pin_oe);
    wait_oe(1'b0, CAL_T + 10);
    rdc("count after write", OFF_CALCOUNT, c + 2);
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    miscompares = 0;
    total_checks = 0;
    cyc = 0;
    rel = 0;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    raw_valid = 1'b0;
    raw_code = 8'h00;
    raw_over = 1'b0;
    wq = '{9'h001, 9'h080, 9'h1FF, 9'h0FE, 9'h07F, 9'h100, 9'h055, 9'h0AA};
    repeat (20) @(posedge hclk);
    t_reset();
    hresetn <= 1'b1;
    rel = cyc;
    t_fill_cal();
    t_ref();
    t_coding();
    t_halve();
    t_pin();
    finish_test();
  end
  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #2000000;
    miscompares++;
    $display("BAD watchdog exp done got hang");
    finish_test();
  end
endmodule
`default_nettype wire
